/* File: verilog/nvmpc_pkg.sv */
`default_nettype none
package nvmpc_pkg;
  // Register indices; the bus byte address is four times the index
  localparam logic [15:0] CTRL_IDX = 16'h0007; // Program control register
  localparam logic [15:0] EEPROM_OPTION_CONFIG_IDX = 16'h0100; // EEPROM option register
  localparam logic [15:0] MOR_IDX  = 16'h3dfe; // Mask option register
  localparam int          IDX_LSB  = 2;        // Word index starts at haddr bit 2
  localparam int          IDX_MSB  = 17;       // Last index bit on the bus
  // Control register bit positions
  localparam int CB_EP_LAT = 5; // EPROM latch enable
  localparam int CB_EP_PGM = 4; // EPROM program enable
  localparam int CB_EE_ERA = 2; // EEPROM erase select
  localparam int CB_EE_LAT = 1; // EEPROM latch enable
  localparam int CB_EE_PMP = 0; // EEPROM charge pump enable
  // Option register bit positions
  localparam int OB_UNPROT = 1; // Upper EEPROM unprotect
  localparam int OB_SEC    = 0; // Security lock (0 = locked)
  // Memory ranges
  localparam logic [15:0] EP_LO    = 16'h0800; // EPROM range start
  localparam logic [15:0] EP_HI    = 16'h3dff; // EPROM range end
  localparam logic [15:0] EE_LO    = 16'h0100; // EEPROM range start
  localparam logic [15:0] EE_HI    = 16'h01ff; // EEPROM range end
  localparam logic [15:0] EE_UPPER = 16'h0120; // First protectable byte
  // Reset pin hold after power-on, in clock cycles
  localparam logic [11:0] POR_HOLD_SHORT_CYC = 12'h010; // 16 cycles
  localparam logic [11:0] POR_HOLD_LONG_CYC  = 12'hfe0; // 4064 cycles
  localparam logic [7:0]  RD_ZERO            = 8'h00;   // Unmapped / reserved
  // EPROM sequence states, one-hot
  typedef enum logic [2:0]
  {
    EP_READ = 3'b001, // Array readable
    EP_LOAD = 3'b010, // Latching address and data
    EP_PROG = 3'b100  // Programming in progress
  } nvmpc_ep_st_t;
  // Mask option bits as read from the EPROM array
  typedef struct packed
  {
    logic [2:0] rsv;              // Unused, read zero
    logic       por_hold_sel;     // 1 = short hold
    logic       wdog_after_reset; // Watchdog runs after reset
    logic       wdog_in_wait;     // Watchdog runs in WAIT
    logic       port_b_pulldown;  // Port B pull-downs
    logic       port_c_pulldown;  // Port C pull-downs
  } nvmpc_mor_t;
  // CPU memory write seen by the block
  typedef struct packed
  {
    logic        valid; // One-cycle write strobe
    logic [15:0] addr;  // CPU address
    logic [7:0]  data;  // Written byte
  } nvmpc_memwr_t;
endpackage
`default_nettype wire

/* File: verilog/nvmpc_byte_buf.sv */
`default_nettype none
// Eight-byte EPROM latch buffer with registered read port
module nvmpc_byte_buf
(
  input  wire logic       hclk,    // Clock
  input  wire logic       hresetn, // Async reset, active low
  input  wire logic       wr_en,   // Write strobe
  input  wire logic [2:0] wr_idx,  // Byte slot
  input  wire logic [7:0] wr_data, // Byte written
  input  wire logic [2:0] rd_idx,  // Slot to read
  output logic      [7:0] rd_data  // Registered read data
);
  typedef struct packed
  {
    logic [7:0][7:0] mem; // Byte slots
    logic [7:0]      rd;  // Read register
  } nvmpc_buf_st_t;
  nvmpc_buf_st_t st_reg;  // Current state
  nvmpc_buf_st_t st_next; // Next state

  // Store on write, read one slot per cycle
  always_comb
  begin
    st_next = st_reg;
    if (wr_en)
    begin
      st_next.mem[wr_idx] = wr_data;
    end
    st_next.rd = st_reg.mem[rd_idx];
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rd_data = st_reg.rd;
endmodule
`default_nettype wire

/* File: verilog/nvmpc_por_hold.sv */
`default_nettype none
// Holds the reset pin low for a selectable count after power-on
module nvmpc_por_hold
(
  input  wire logic hclk,      // Clock
  input  wire logic hresetn,   // Async reset, active low
  input  wire logic short_sel, // 1 = short hold, sampled after release
  output logic      hold_low   // High while the reset pin is held low
);
  typedef struct packed
  {
    logic        busy;    // Hold running
    logic        started; // Target taken
    logic [11:0] tgt;     // Hold length
    logic [11:0] cnt;     // Cycles held so far
  } nvmpc_por_st_t;
  nvmpc_por_st_t st_reg;  // Current state
  nvmpc_por_st_t st_next; // Next state
  logic [11:0]   tgt_now; // Target in force this cycle

  // Target is sampled once so a strap change cannot stretch the hold
  always_comb
  begin
    st_next = st_reg;
    tgt_now = st_reg.started ? st_reg.tgt
            : (short_sel ? nvmpc_pkg::POR_HOLD_SHORT_CYC : nvmpc_pkg::POR_HOLD_LONG_CYC);
    if (st_reg.busy)
    begin
      st_next.started = 1'b1;
      st_next.tgt     = tgt_now;
      st_next.cnt     = st_reg.cnt + 12'h001;
      if (st_reg.cnt == tgt_now - 12'h001)
      begin
        st_next.busy = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= '{busy: 1'b1, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign hold_low = st_reg.busy;

  property p_hold_len;
    @(posedge hclk) disable iff (!hresetn)
    $fell(hold_low) |-> (st_reg.cnt == st_reg.tgt)
      && (st_reg.tgt == nvmpc_pkg::POR_HOLD_SHORT_CYC || st_reg.tgt == nvmpc_pkg::POR_HOLD_LONG_CYC);
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("reset hold length wrong");
endmodule
`default_nettype wire

/* File: verilog/nvmpc_top.sv */
`default_nettype none
module nvmpc_top
(
  input  wire logic                    hclk,             // Clock, 250 MHz
  input  wire logic                    hresetn,          // Power-on or external reset
  input  wire logic                    hsel,             // AHB select
  input  wire logic [31:0]             haddr,            // AHB address
  input  wire logic [1:0]              htrans,           // AHB transfer type
  input  wire logic                    hwrite,           // AHB write
  input  wire logic [2:0]              hsize,            // AHB size, word only
  input  wire logic [31:0]             hwdata,           // AHB write data
  input  wire logic                    hready,           // AHB bus ready
  output logic      [31:0]             hrdata,           // AHB read data
  output logic                         hreadyout,        // Slave ready
  output logic                         hresp,            // Always OKAY
  input  wire nvmpc_pkg::nvmpc_memwr_t cpu_wr,           // CPU memory writes
  input  wire logic                    stop_entry,       // STOP mode entry pulse
  input  wire logic                    bootstrap_mode,   // Bootstrap strap
  input  wire nvmpc_pkg::nvmpc_mor_t   mor_array,        // Mask option array bits
  input  wire logic [1:0]              eeprom_option_config_array,       // Option array bits
  input  wire logic [7:0]              ddr_b,            // Port B direction, 1 = out
  input  wire logic [7:0]              ddr_c,            // Port C direction, 1 = out
  input  wire logic [2:0]              ep_buf_rd_idx,    // Latched byte to read
  output logic      [7:0]              ep_buf_rd_data,   // Latched byte
  output logic      [7:0]              ep_byte_valid,    // Latched byte slots
  output logic      [12:0]             ep_group_addr,    // Latched group address
  output logic                         eprom_prog_en,    // Program pulse to array
  output logic                         eprom_readable,   // Array contents valid
  output logic                         eeprom_hv_en,     // High voltage to EEPROM
  output logic                         eeprom_erase,     // 1 = erase, 0 = program
  output logic      [7:0]              eeprom_addr,      // Target byte offset
  output logic      [7:0]              eeprom_data,      // Byte to program
  output logic                         eeprom_readable,  // EEPROM reads valid
  output logic                         reset_pin_low,    // Drive reset pin low
  output logic                         wdog_run_reset,   // Watchdog on after reset
  output logic                         wdog_run_wait,    // Watchdog on in WAIT
  output logic      [7:0]              port_b_pd_en,     // Port B pull-downs
  output logic      [7:0]              port_c_pd_en,     // Port C pull-downs
  output logic                         nonuser_allow     // Non-user modes allowed
);
  typedef struct packed
  {
    nvmpc_pkg::nvmpc_ep_st_t ep_st;   // EPROM sequence
    logic                    ep_byte; // Byte written since latching
    logic [12:0]             ep_grp;  // Group address
    logic [7:0]              ep_vld;  // Slot valid mask
    logic                    ee_lat;  // EEPROM latch enable
    logic                    ee_era;  // EEPROM erase select
    logic                    ee_pmp;  // EEPROM pump enable
    logic                    ee_cap;  // Target address captured
    logic [7:0]              ee_adr;  // Target offset
    logic [7:0]              ee_dat;  // Target data
    logic                    unprot;  // Upper unprotect, live
    logic                    sec_wr;  // Security bit as written
    logic                    sec;     // Security in force
    nvmpc_pkg::nvmpc_mor_t   option_mask_config;     // Captured options
    logic                    boot;    // Captured bootstrap
    logic                    init;    // Options captured
    logic                    dp_wr;   // Write data phase pending
    logic [1:0]              dp_sel;  // 0 ctrl, 1 eeprom_option_config, 2 mor, 3 none
    logic [31:0]             rdata;   // Read data register
  } nvmpc_st_t;
  nvmpc_st_t   st_reg;  // Current state
  nvmpc_st_t   st_next; // Next state
  logic        ap_take; // Address phase accepted
  logic [1:0]  ap_sel;  // Register decoded in address phase
  logic [7:0]  wb;      // Written byte
  logic        ep_hit;  // CPU write in EPROM range
  logic        ee_hit;  // CPU write in EEPROM range
  logic        ep_take; // EPROM byte accepted into the group
  logic        ee_up;   // Target in upper EEPROM
  logic [7:0]  rd_byte; // Read value

  assign ap_take = hsel && htrans[1] && hready;
  assign wb      = hwdata[7:0];
  assign ep_hit  = cpu_wr.valid && cpu_wr.addr >= nvmpc_pkg::EP_LO && cpu_wr.addr <= nvmpc_pkg::EP_HI;
  assign ee_hit  = cpu_wr.valid && cpu_wr.addr >= nvmpc_pkg::EE_LO && cpu_wr.addr <= nvmpc_pkg::EE_HI;
  // One strobe feeds both the slot flags and the byte store, so a flag clear never writes a stale byte
  assign ep_take = ep_hit && st_reg.ep_st == nvmpc_pkg::EP_LOAD
                   && (!st_reg.ep_byte || cpu_wr.addr[15:3] == st_reg.ep_grp);
  assign ee_up   = {8'h01, st_reg.ee_adr} >= nvmpc_pkg::EE_UPPER;

  // Address decode; indices sit above the word offset
  always_comb
  begin
    ap_sel = 2'd3;
    if (haddr[31:nvmpc_pkg::IDX_MSB+1] == '0)
    begin
      case (haddr[nvmpc_pkg::IDX_MSB:nvmpc_pkg::IDX_LSB])
        nvmpc_pkg::CTRL_IDX: ap_sel = 2'd0;
        nvmpc_pkg::EEPROM_OPTION_CONFIG_IDX: ap_sel = 2'd1;
        nvmpc_pkg::MOR_IDX:  ap_sel = 2'd2;
        default:             ap_sel = 2'd3;
      endcase
    end
  end

  // Next state: bus writes, CPU memory writes, STOP, then read data
  always_comb
  begin
    st_next = st_reg;
    rd_byte = nvmpc_pkg::RD_ZERO;
    // Options are caught once, on the first edge after release
    if (!st_reg.init)
    begin
      st_next.init   = 1'b1;
      st_next.option_mask_config    = mor_array;
      st_next.boot   = bootstrap_mode;
      st_next.unprot = eeprom_option_config_array[nvmpc_pkg::OB_UNPROT];
      st_next.sec_wr = eeprom_option_config_array[nvmpc_pkg::OB_SEC];
      st_next.sec    = eeprom_option_config_array[nvmpc_pkg::OB_SEC];
    end
    // Control register write
    if (st_reg.dp_wr && st_reg.dp_sel == 2'd0)
    begin
      case (st_reg.ep_st)
        nvmpc_pkg::EP_READ:
        begin
          if (wb[nvmpc_pkg::CB_EP_LAT])
          begin
            st_next.ep_st   = nvmpc_pkg::EP_LOAD;
            st_next.ep_byte = 1'b0;
            st_next.ep_vld  = '0;
          end
        end
        nvmpc_pkg::EP_LOAD:
        begin
          if (!wb[nvmpc_pkg::CB_EP_LAT])
          begin
            st_next.ep_st = nvmpc_pkg::EP_READ;
          end
          else if (wb[nvmpc_pkg::CB_EP_PGM] && st_reg.ep_byte)
          begin
            st_next.ep_st = nvmpc_pkg::EP_PROG;
          end
        end
        nvmpc_pkg::EP_PROG:
        begin
          // Writing zero to the enable does nothing; only unlatching ends it
          if (!wb[nvmpc_pkg::CB_EP_LAT])
          begin
            st_next.ep_st = nvmpc_pkg::EP_READ;
          end
        end
        default: st_next.ep_st = nvmpc_pkg::EP_READ;
      endcase
      st_next.ee_lat = wb[nvmpc_pkg::CB_EE_LAT];
      if (!wb[nvmpc_pkg::CB_EE_LAT])
      begin
        st_next.ee_era = 1'b0;
        st_next.ee_pmp = 1'b0;
        st_next.ee_cap = 1'b0;
      end
      else
      begin
        if (!st_reg.ee_cap)
        begin
          st_next.ee_era = wb[nvmpc_pkg::CB_EE_ERA];
        end
        if (wb[nvmpc_pkg::CB_EE_PMP] && st_reg.ee_lat && st_reg.ee_cap)
        begin
          st_next.ee_pmp = 1'b1;
        end
      end
    end
    // Option register write
    if (st_reg.dp_wr && st_reg.dp_sel == 2'd1)
    begin
      if (!wb[nvmpc_pkg::OB_UNPROT] && st_reg.ee_lat)
      begin
        st_next.unprot = 1'b0;
      end
      st_next.sec_wr = wb[nvmpc_pkg::OB_SEC];
    end
    // EPROM byte capture: only bytes of the first group are kept
    if (ep_take)
    begin
      st_next.ep_byte                  = 1'b1;
      st_next.ep_grp                   = cpu_wr.addr[15:3];
      st_next.ep_vld[cpu_wr.addr[2:0]] = 1'b1;
    end
    // EEPROM target capture while latched and pump off
    if (ee_hit && st_reg.ee_lat && !st_reg.ee_pmp)
    begin
      st_next.ee_cap = 1'b1;
      st_next.ee_adr = cpu_wr.addr[7:0];
      st_next.ee_dat = cpu_wr.data;
    end
    // STOP drops both latches, program enable, erase select, pump and capture; slot mask and group stay
    if (stop_entry)
    begin
      st_next.ep_st  = nvmpc_pkg::EP_READ;
      st_next.ee_lat = 1'b0;
      st_next.ee_era = 1'b0;
      st_next.ee_pmp = 1'b0;
      st_next.ee_cap = 1'b0;
    end
    // Bus phase tracking; reads see the updated value
    if (hready)
    begin
      st_next.dp_wr  = ap_take && hwrite;
      st_next.dp_sel = ap_sel;
    end
    case (ap_sel)
      2'd0:
      begin
        rd_byte[nvmpc_pkg::CB_EP_LAT] = st_next.ep_st != nvmpc_pkg::EP_READ;
        rd_byte[nvmpc_pkg::CB_EP_PGM] = st_next.ep_st == nvmpc_pkg::EP_PROG;
        rd_byte[nvmpc_pkg::CB_EE_ERA] = st_next.ee_era;
        rd_byte[nvmpc_pkg::CB_EE_LAT] = st_next.ee_lat;
        rd_byte[nvmpc_pkg::CB_EE_PMP] = st_next.ee_pmp;
      end
      2'd1:
      begin
        rd_byte[nvmpc_pkg::OB_UNPROT] = st_next.unprot;
        rd_byte[nvmpc_pkg::OB_SEC]    = st_next.sec_wr;
      end
      2'd2:    rd_byte = {3'b000, st_next.option_mask_config[4:0]};
      default: rd_byte = nvmpc_pkg::RD_ZERO;
    endcase
    if (ap_take && !hwrite)
    begin
      st_next.rdata = {24'h00_0000, rd_byte};
    end
  end

  // State register; reset clears both latches
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_reg <= '{ep_st: nvmpc_pkg::EP_READ, dp_sel: 2'd3, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Latched EPROM bytes
  nvmpc_byte_buf u_buf
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr_en   (ep_take),
    .wr_idx  (cpu_wr.addr[2:0]),
    .wr_data (cpu_wr.data),
    .rd_idx  (ep_buf_rd_idx),
    .rd_data (ep_buf_rd_data)
  );

  // Reset pin hold after power-on
  nvmpc_por_hold u_por
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .short_sel (mor_array.por_hold_sel),
    .hold_low  (reset_pin_low)
  );

  // Outputs
  assign hrdata          = st_reg.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign ep_byte_valid   = st_reg.ep_vld;
  assign ep_group_addr   = st_reg.ep_grp;
  assign eprom_prog_en   = st_reg.ep_st == nvmpc_pkg::EP_PROG;
  assign eprom_readable  = st_reg.ep_st == nvmpc_pkg::EP_READ;
  assign eeprom_erase    = st_reg.ee_era;
  assign eeprom_addr     = st_reg.ee_adr;
  assign eeprom_data     = st_reg.ee_dat;
  assign eeprom_readable = !st_reg.ee_lat;
  // Upper part stays untouched unless unprotected or in bootstrap
  assign eeprom_hv_en    = st_reg.ee_pmp && (!ee_up || st_reg.unprot || st_reg.boot);
  assign wdog_run_reset  = st_reg.init && st_reg.option_mask_config.wdog_after_reset && !st_reg.boot;
  assign wdog_run_wait   = st_reg.init && st_reg.option_mask_config.wdog_in_wait;
  assign nonuser_allow   = st_reg.init && st_reg.sec;

  // Pull-downs only on pins that are inputs
  for (genvar i = 0; i < 8; i++)
  begin : g_pd
    assign port_b_pd_en[i] = st_reg.init && st_reg.option_mask_config.port_b_pulldown && !ddr_b[i];
    assign port_c_pd_en[i] = st_reg.init && st_reg.option_mask_config.port_c_pulldown && !ddr_c[i];
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_prog_rise;
    !eprom_prog_en ##1 eprom_prog_en;
  endsequence
  property p_prog_cause;
    s_prog_rise |-> $past(st_reg.ep_byte, 1) && !$past(eprom_readable, 1);
  endproperty
  a_prog_cause: assert property (p_prog_cause) else $error("program enable set without byte");
  property p_prog_latch;
    eprom_prog_en |-> !eprom_readable;
  endproperty
  a_prog_latch: assert property (p_prog_latch) else $error("program enable without latch");
  property p_prog_hold;
    $past(eprom_prog_en) && !eprom_readable |-> eprom_prog_en;
  endproperty
  a_prog_hold: assert property (p_prog_hold) else $error("program enable cleared alone");
  property p_stop_clear;
    stop_entry |=> eprom_readable && !eprom_prog_en && !st_reg.ee_lat && !st_reg.ee_pmp;
  endproperty
  a_stop_clear: assert property (p_stop_clear) else $error("STOP left a latch set");
  property p_ee_unlatched;
    !st_reg.ee_lat |-> !st_reg.ee_era && !st_reg.ee_pmp;
  endproperty
  a_ee_unlatched: assert property (p_ee_unlatched) else $error("select or pump without latch");
  sequence s_pump_rise;
    !st_reg.ee_pmp ##1 st_reg.ee_pmp;
  endsequence
  property p_pump_cause;
    s_pump_rise |-> $past(st_reg.ee_cap, 1);
  endproperty
  a_pump_cause: assert property (p_pump_cause) else $error("pump on before data latched");
  property p_era_frozen;
    $past(st_reg.ee_cap) && st_reg.ee_cap |-> $stable(st_reg.ee_era);
  endproperty
  a_era_frozen: assert property (p_era_frozen) else $error("erase select changed after capture");
  property p_upper_block;
    eeprom_hv_en && ee_up |-> st_reg.unprot || st_reg.boot;
  endproperty
  a_upper_block: assert property (p_upper_block) else $error("upper EEPROM reached while protected");
  property p_unprot_clear;
    st_reg.init && $fell(st_reg.unprot) |-> $past(st_reg.ee_lat);
  endproperty
  a_unprot_clear: assert property (p_unprot_clear) else $error("unprotect cleared unlatched");
endmodule
`default_nettype wire

/* File: verif/tb_nvmpc_top.sv */
`default_nettype none
module tb_nvmpc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    hclk, hresetn, hsel, hwrite, hreadyout, hresp;  // Clock, reset, bus control
  logic [31:0]             haddr, hwdata, hrdata, rd;                      // Bus address and data
  logic [1:0]              htrans;                                         // Transfer type
  logic                    stop_entry, eprom_prog_en, eprom_readable;      // STOP pulse, EPROM status
  logic                    eeprom_hv_en, eeprom_erase, eeprom_readable;    // EEPROM status
  logic                    reset_pin_low, wdog_run_reset, wdog_run_wait;   // Reset hold, watchdog
  logic                    nonuser_allow;                                  // Security result
  logic [7:0]              ep_buf_rd_data, ep_byte_valid, eeprom_addr;     // Latched EPROM/EEPROM data
  logic [7:0]              eeprom_data, port_b_pd_en, port_c_pd_en;        // Byte and pull-downs
  logic [12:0]             ep_group_addr;                                  // Latched group
  logic [2:0]              hsize, ep_buf_rd_idx;                           // Transfer size, slot to read
  logic                    bootstrap_mode;                                 // Bootstrap strap
  nvmpc_pkg::nvmpc_memwr_t cpu_wr;                                         // CPU memory write
  int                      error_cnt, total_checks;                        // Counters
  localparam logic [15:0]  CT = nvmpc_pkg::CTRL_IDX;                       // Control index
  localparam logic [15:0]  OP = nvmpc_pkg::EEPROM_OPTION_CONFIG_IDX;                       // Option index
  // Bus ready loops back from the only slave
  nvmpc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cpu_wr(cpu_wr), .stop_entry(stop_entry), .bootstrap_mode(bootstrap_mode), .mor_array(8'h1a),
    .eeprom_option_config_array(2'h3), .ddr_b(8'hf0), .ddr_c(8'h00), .ep_buf_rd_idx(ep_buf_rd_idx),
    .ep_buf_rd_data(ep_buf_rd_data),
    .ep_byte_valid(ep_byte_valid), .ep_group_addr(ep_group_addr), .eprom_prog_en(eprom_prog_en),
    .eprom_readable(eprom_readable), .eeprom_hv_en(eeprom_hv_en), .eeprom_erase(eeprom_erase),
    .eeprom_addr(eeprom_addr), .eeprom_data(eeprom_data), .eeprom_readable(eeprom_readable),
    .reset_pin_low(reset_pin_low), .wdog_run_reset(wdog_run_reset), .wdog_run_wait(wdog_run_wait),
    .port_b_pd_en(port_b_pd_en), .port_c_pd_en(port_c_pd_en), .nonuser_allow(nonuser_allow));
  // Free running 250 MHz clock
  always #2 hclk = ~hclk;
  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One single AHB transfer; waits on ready, no fixed latency assumed
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    haddr <= {14'h0000, idx, 2'b00};
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h00_0000, exp});
  endtask
  // Let the edge's updates land before looking at outputs
  task automatic settle();
    @(posedge hclk);
    #1;
  endtask
  task automatic mem(input logic [15:0] a, input logic [7:0] d);
    @(posedge hclk);
    cpu_wr <= {1'b1, a, d};
    @(posedge hclk);
    cpu_wr.valid <= 1'b0;
  endtask
  task automatic stop_pulse();
    @(posedge hclk);
    stop_entry <= 1'b1;
    @(posedge hclk);
    stop_entry <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, far beyond the roughly 160 cycles the tests need
  initial
  begin
    repeat (3000) @(posedge hclk);
    error_cnt++;
    end_sim();
  end
  initial
  begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, stop_entry, cpu_wr, hsize, bootstrap_mode} = '0;
    ep_buf_rd_idx = 3'h3;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (15) settle();
    chk(reset_pin_low, 1'b1);
    settle();
    chk(reset_pin_low, 1'b0);
    chk({wdog_run_reset, wdog_run_wait, nonuser_allow}, 3'b101);
    chk({port_b_pd_en, port_c_pd_en}, 16'h0f00);
    rchk(CT, 8'h00);
    rchk(nvmpc_pkg::MOR_IDX, 8'h1a);
    rchk(16'h0050, 8'h00);
    chk(hresp, 1'b0);
    bus(1'b1, CT, 8'h10);
    rchk(CT, 8'h00);
    bus(1'b1, CT, 8'h20);
    bus(1'b1, CT, 8'h30);
    rchk(CT, 8'h20);
    mem(16'h0803, 8'h5a);
    mem(16'h0f00, 8'h11);
    mem(16'h0806, 8'h77);
    settle();
    chk(ep_byte_valid, 8'h48);
    chk({ep_group_addr, ep_buf_rd_data, eprom_readable}, {13'h0100, 8'h5a, 1'b0});
    @(posedge hclk);
    ep_buf_rd_idx <= 3'h6;
    settle();
    chk(ep_buf_rd_data, 8'h77);
    bus(1'b1, CT, 8'h30);
    rchk(CT, 8'h30);
    mem(16'h0801, 8'h22);
    settle();
    chk({ep_byte_valid, eprom_prog_en}, {8'h48, 1'b1});
    bus(1'b1, CT, 8'h20);
    rchk(CT, 8'h30);
    bus(1'b1, CT, 8'h00);
    rchk(CT, 8'h00);
    chk({eprom_prog_en, eprom_readable}, 2'b01);
    bus(1'b1, CT, 8'h20);
    stop_pulse();
    rchk(CT, 8'h00);
    bus(1'b1, OP, 8'h01);
    rchk(OP, 8'h03);
    bus(1'b1, CT, 8'h03);
    rchk(CT, 8'h02);
    bus(1'b1, OP, 8'h01);
    rchk(OP, 8'h01);
    mem(16'h0105, 8'h33);
    bus(1'b1, CT, 8'h06);
    rchk(CT, 8'h02);
    bus(1'b1, CT, 8'h03);
    settle();
    chk({eeprom_hv_en, eeprom_erase, eeprom_addr, eeprom_data}, {2'b10, 16'h0533});
    stop_pulse();
    rchk(CT, 8'h00);
    chk({eeprom_readable, eeprom_hv_en, eeprom_erase}, 3'b100);
    bus(1'b1, CT, 8'h06);
    mem(16'h0150, 8'hff);
    bus(1'b1, CT, 8'h07);
    rchk(CT, 8'h07);
    chk({eeprom_erase, eeprom_hv_en}, 2'b10);
    // Security write shows at once but never reaches nonuser_allow, which takes the array bit at each reset
    bus(1'b1, OP, 8'h00);
    rchk(OP, 8'h00);
    chk(nonuser_allow, 1'b1);
    // Second reset in mid-run, with the bootstrap strap high
    @(posedge hclk);
    hresetn        <= 1'b0;
    bootstrap_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk({reset_pin_low, wdog_run_reset, eeprom_readable}, 3'b101);
    rchk(CT, 8'h00);
    bus(1'b1, CT, 8'h02);
    bus(1'b1, OP, 8'h01);
    rchk(OP, 8'h01);
    mem(16'h0150, 8'hff);
    bus(1'b1, CT, 8'h03);
    settle();
    chk({eeprom_hv_en, eeprom_addr}, {1'b1, 8'h50});
    end_sim();
  end
endmodule
`default_nettype wire
